/* logic/bridge_err_cfg.svh */
// offsets, field positions, reset values and codes of the error, clock-run and retry block
`ifndef BRIDGE_ERR_CFG_SVH
`define BRIDGE_ERR_CFG_SVH
// register byte offsets
`define OFF_COMMAND       8'h04
`define OFF_EVENT_DISABLE 8'h64
`define OFF_SERR_STATUS   8'h68
`define OFF_CLOCK_RUN     8'h6c
`define OFF_RETRY_OPTIONS 8'h74
// field positions
`define CMD_SERR_EN_BIT   8
`define STATUS_LSB        16
`define STATUS_MSB        23
`define DISABLE_LSB       1
`define DISABLE_MSB       6
`define CR_SEC_STOPPED    24
`define CR_SEC_EN         25
`define CR_PRI_KEEP       26
`define CR_PRI_EN         27
`define CR_MODE           28
`define OPT_PRI_RD_ALIAS  1
`define OPT_PRI_WR_ALIAS  2
`define OPT_SEC_RD_ALIAS  3
`define OPT_SEC_WR_ALIAS  4
`define OPT_PRI_LM_ALIAS  5
`define OPT_SEC_LM_ALIAS  6
// reset values
`define OPTIONS_RESET     7'h6a
`define RETRY_LIMIT_DFLT  25'h1000000
// pci command codes
`define CMD_MEM_READ      4'h6
`define CMD_MEM_WRITE     4'h7
`define CMD_MEM_READ_MULT 4'hc
`define CMD_MEM_READ_LINE 4'he
`define CMD_MEM_WRITE_INV 4'hf
`endif

/* logic/bridge_err_pkg.sv */
// types of the error, clock-run and retry block
package bridge_err_pkg;
    // index of each system-error event in the status byte
    typedef enum logic [2:0] {
        EV_ADDR_PARITY   = 3'b000,
        EV_POSTED_PARITY = 3'b001,
        EV_POSTED_NODLV  = 3'b010,
        EV_POSTED_TABORT = 3'b011,
        EV_POSTED_MABORT = 3'b100,
        EV_DWRITE_NODLV  = 3'b101,
        EV_DREAD_NODATA  = 3'b110,
        EV_MASTER_TMO    = 3'b111
    } serr_event_e;
    // secondary clock state
    typedef enum logic [0:0] {
        SCLK_RUN  = 1'b0,
        SCLK_STOP = 1'b1
    } sclk_state_e;
    typedef logic [24:0] retry_cnt_t;
endpackage

/* logic/bridge_error_clockrun_retry_options.sv */
// system-error status, clock-run control and retry matching options of a pci bridge
//
// Strobed register access was left to the implementer.
`include "bridge_err_cfg.svh"

module bridge_error_clockrun_retry_options #(
    parameter logic [24:0] RETRY_LIMIT = `RETRY_LIMIT_DFLT
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [31:0] reg_rdata,
    // error events from the bridge core
    input  wire logic        addr_parity_evt,
    input  wire logic        posted_parity_evt,
    input  wire logic        posted_tabort_evt,
    input  wire logic        posted_mabort_evt,
    input  wire logic        master_timeout_evt,
    // delivery attempts: 0 posted, 1 delayed write, 2 delayed read
    input  wire logic [2:0]  attempt_fail,
    input  wire logic [2:0]  attempt_done,
    // system error
    output      logic        primary_system_error_out,
    // clock-run
    input  wire logic        pri_stop_req,
    input  wire logic        sec_bus_idle,
    input  wire logic        pri_req_pending,
    output      logic        sec_clock_run_control_en,
    output      logic        pri_clock_run_control_en,
    output      logic        sec_clk_stopped,
    output      logic        pri_clk_stop_allow,
    // retry matching: primary
    input  wire logic [3:0]  pri_retry_cmd,
    input  wire logic [3:0]  pri_queued_cmd,
    output      logic        pri_cmd_match,
    // retry matching: secondary
    input  wire logic [3:0]  sec_retry_cmd,
    input  wire logic [3:0]  sec_queued_cmd,
    output      logic        sec_cmd_match
);

    logic                     serr_en_r;
    logic [`DISABLE_MSB:`DISABLE_LSB] disable_r;
    logic [7:0]               status_r;
    logic                     sec_en_r;
    logic                     pri_keep_r;
    logic                     pri_en_r;
    logic                     mode_r;
    logic [6:0]               options_r;
    bridge_err_pkg::retry_cnt_t cnt_r [3];
    logic [2:0]               nodlv;
    logic [7:0]               raw_evt;
    logic [7:0]               evt_mask;
    logic [7:0]               serr_fire;
    logic [7:0]               status_nxt;
    bridge_err_pkg::sclk_state_e sclk_r;
    bridge_err_pkg::sclk_state_e sclk_nxt;
    logic                     stop_cond;
    logic [31:0]              rdata_nxt;

    // counter step: cleared on delivery, saturates at the limit
    function automatic bridge_err_pkg::retry_cnt_t cnt_step(
        input bridge_err_pkg::retry_cnt_t cnt,
        input logic fail,
        input logic done
    );
        bridge_err_pkg::retry_cnt_t r;
        r = cnt;
        if (done) begin
            r = '0;
        end else if (fail && cnt != RETRY_LIMIT) begin
            r = cnt + 25'h0000001;
        end
        return r;
    endfunction

    // is the command a line or multiple read
    function automatic logic is_lm_read(input logic [3:0] c);
        return (c == `CMD_MEM_READ_LINE) || (c == `CMD_MEM_READ_MULT);
    endfunction

    // retry command against queued command under the alias options
    function automatic logic cmd_match(
        input logic [3:0] retry,
        input logic [3:0] queued,
        input logic       rd_alias,
        input logic       wr_alias,
        input logic       lm_alias
    );
        logic m;
        m = (retry == queued);
        if (rd_alias && is_lm_read(retry) && queued == `CMD_MEM_READ) begin
            m = 1'b1;
        end
        if (lm_alias && is_lm_read(retry) && is_lm_read(queued)) begin
            m = 1'b1;
        end
        if (wr_alias && retry == `CMD_MEM_WRITE_INV && queued == `CMD_MEM_WRITE) begin
            m = 1'b1;
        end
        return m;
    endfunction

    // retry counters, one per transaction kind
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (rst) begin
                cnt_r[i] <= '0;
            end else begin
                cnt_r[i] <= cnt_step(cnt_r[i], attempt_fail[i], attempt_done[i]);
            end
        end
    end

    // non-delivery on the attempt that reaches the limit
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nodlv[i] = attempt_fail[i] && !attempt_done[i]
                       && (cnt_r[i] == RETRY_LIMIT - 25'h0000001);
        end
    end

    // event vector in status bit order
    always_comb begin
        raw_evt = '0;
        raw_evt[bridge_err_pkg::EV_ADDR_PARITY]   = addr_parity_evt;
        raw_evt[bridge_err_pkg::EV_POSTED_PARITY] = posted_parity_evt;
        raw_evt[bridge_err_pkg::EV_POSTED_NODLV]  = nodlv[0];
        raw_evt[bridge_err_pkg::EV_POSTED_TABORT] = posted_tabort_evt;
        raw_evt[bridge_err_pkg::EV_POSTED_MABORT] = posted_mabort_evt;
        raw_evt[bridge_err_pkg::EV_DWRITE_NODLV]  = nodlv[1];
        raw_evt[bridge_err_pkg::EV_DREAD_NODATA]  = nodlv[2];
        raw_evt[bridge_err_pkg::EV_MASTER_TMO]    = master_timeout_evt;
    end

    // gating by disable bits and command enable
    assign evt_mask  = {1'b0, disable_r, 1'b0};
    assign serr_fire = raw_evt & ~evt_mask & {8{serr_en_r}};

    // system error pulse
    always_ff @(posedge core_clk) begin
        if (rst) begin
            primary_system_error_out <= 1'b0;
        end else begin
            primary_system_error_out <= |serr_fire;
        end
    end

    // status: write one clears, a new event wins over the clear
    always_comb begin
        status_nxt = status_r;
        if (reg_wr && reg_addr == `OFF_SERR_STATUS) begin
            status_nxt = status_r & ~reg_wdata[`STATUS_MSB:`STATUS_LSB];
        end
        status_nxt = status_nxt | serr_fire;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_r <= 8'h00;
        end else begin
            status_r <= status_nxt;
        end
    end

    // command enable and event disable registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serr_en_r <= 1'b0;
            disable_r <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `OFF_COMMAND) begin
                serr_en_r <= reg_wdata[`CMD_SERR_EN_BIT];
            end
            if (reg_addr == `OFF_EVENT_DISABLE) begin
                disable_r <= reg_wdata[`DISABLE_MSB:`DISABLE_LSB];
            end
        end
    end

    // clock-run control
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sec_en_r   <= 1'b0;
            pri_keep_r <= 1'b0;
            pri_en_r   <= 1'b0;
            mode_r     <= 1'b0;
        end else if (reg_wr && reg_addr == `OFF_CLOCK_RUN) begin
            sec_en_r   <= reg_wdata[`CR_SEC_EN];
            pri_keep_r <= reg_wdata[`CR_PRI_KEEP];
            pri_en_r   <= reg_wdata[`CR_PRI_EN];
            mode_r     <= reg_wdata[`CR_MODE];
        end
    end

    // stop condition for the secondary clock
    assign stop_cond = mode_r ? (sec_bus_idle && !pri_req_pending) : pri_stop_req;

    // secondary clock state
    always_comb begin
        sclk_nxt = sclk_r;
        unique case (sclk_r)
            bridge_err_pkg::SCLK_RUN: begin
                if (sec_en_r && stop_cond) begin
                    sclk_nxt = bridge_err_pkg::SCLK_STOP;
                end
            end
            bridge_err_pkg::SCLK_STOP: begin
                if (!sec_en_r || !stop_cond) begin
                    sclk_nxt = bridge_err_pkg::SCLK_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclk_r <= bridge_err_pkg::SCLK_RUN;
        end else begin
            sclk_r <= sclk_nxt;
        end
    end

    // clock-run outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sec_clock_run_control_en      <= 1'b0;
            pri_clock_run_control_en      <= 1'b0;
            sec_clk_stopped    <= 1'b0;
            pri_clk_stop_allow <= 1'b0;
        end else begin
            sec_clock_run_control_en      <= sec_en_r;
            pri_clock_run_control_en      <= pri_en_r;
            sec_clk_stopped    <= (sclk_nxt == bridge_err_pkg::SCLK_STOP);
            pri_clk_stop_allow <= pri_en_r && !pri_keep_r
                                  && (sclk_nxt == bridge_err_pkg::SCLK_STOP);
        end
    end

    // retry option register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            options_r <= `OPTIONS_RESET;
        end else if (reg_wr && reg_addr == `OFF_RETRY_OPTIONS) begin
            options_r <= {reg_wdata[`OPT_SEC_LM_ALIAS:`OPT_PRI_RD_ALIAS], 1'b0};
        end
    end

    // registered match results
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_cmd_match <= 1'b0;
            sec_cmd_match <= 1'b0;
        end else begin
            pri_cmd_match <= cmd_match(pri_retry_cmd, pri_queued_cmd,
                                       options_r[`OPT_PRI_RD_ALIAS],
                                       options_r[`OPT_PRI_WR_ALIAS],
                                       options_r[`OPT_PRI_LM_ALIAS]);
            sec_cmd_match <= cmd_match(sec_retry_cmd, sec_queued_cmd,
                                       options_r[`OPT_SEC_RD_ALIAS],
                                       options_r[`OPT_SEC_WR_ALIAS],
                                       options_r[`OPT_SEC_LM_ALIAS]);
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        rdata_nxt = '0;
        unique case (reg_addr)
            `OFF_COMMAND: rdata_nxt[`CMD_SERR_EN_BIT] = serr_en_r;
            `OFF_EVENT_DISABLE: rdata_nxt[`DISABLE_MSB:`DISABLE_LSB] = disable_r;
            `OFF_SERR_STATUS: rdata_nxt[`STATUS_MSB:`STATUS_LSB] = status_r;
            `OFF_CLOCK_RUN: begin
                rdata_nxt[`CR_SEC_STOPPED] = (sclk_r == bridge_err_pkg::SCLK_STOP);
                rdata_nxt[`CR_SEC_EN]      = sec_en_r;
                rdata_nxt[`CR_PRI_KEEP]    = pri_keep_r;
                rdata_nxt[`CR_PRI_EN]      = pri_en_r;
                rdata_nxt[`CR_MODE]        = mode_r;
            end
            `OFF_RETRY_OPTIONS: rdata_nxt[6:0] = options_r;
            default: rdata_nxt = '0;
        endcase
    end

    // read data only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 32'h00000000;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_addr_parity;
        addr_parity_evt && serr_en_r |=> status_r[0] && primary_system_error_out;
    endproperty
    a_addr_parity: assert property (p_addr_parity)
        else $error("address parity did not set status");

    property p_w1c;
        reg_wr && reg_addr == `OFF_SERR_STATUS && reg_wdata[17] && !serr_fire[1]
            |=> !status_r[1];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear status");

    property p_set_wins;
        reg_wr && reg_addr == `OFF_SERR_STATUS && reg_wdata[20] && serr_fire[4]
            |=> status_r[4];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost under clear");

    property p_disabled;
        posted_tabort_evt && disable_r[3] && !(|(serr_fire & 8'hf7)) |=>
            !primary_system_error_out && !$rose(status_r[3]);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled event raised system error");

    property p_nodlv;
        attempt_fail[0] && !attempt_done[0] && cnt_r[0] == RETRY_LIMIT - 25'h0000001
            && serr_en_r && !disable_r[2] |=> status_r[2] && cnt_r[0] == RETRY_LIMIT;
    endproperty
    a_nodlv: assert property (p_nodlv)
        else $error("posted non-delivery not flagged");

    property p_stop_read;
        reg_rd && reg_addr == `OFF_CLOCK_RUN |=>
            reg_rdata[`CR_SEC_STOPPED] == $past(sclk_r == bridge_err_pkg::SCLK_STOP);
    endproperty
    a_stop_read: assert property (p_stop_read)
        else $error("clock stopped bit wrong");

    property p_sec_stop;
        sec_en_r && !mode_r && pri_stop_req |=> sec_clk_stopped;
    endproperty
    a_sec_stop: assert property (p_sec_stop)
        else $error("secondary clock not stopped on request");

    property p_pri_keep;
        pri_keep_r ##1 pri_keep_r |-> !pri_clk_stop_allow;
    endproperty
    a_pri_keep: assert property (p_pri_keep)
        else $error("primary clock allowed to stop");

    property p_lm_alias;
        options_r[`OPT_PRI_LM_ALIAS] && pri_retry_cmd == `CMD_MEM_READ_LINE
            && pri_queued_cmd == `CMD_MEM_READ_MULT |=> pri_cmd_match;
    endproperty
    a_lm_alias: assert property (p_lm_alias)
        else $error("line and multiple reads not aliased");

    property p_exact;
        !options_r[`OPT_SEC_RD_ALIAS] && !options_r[`OPT_SEC_LM_ALIAS]
            && sec_retry_cmd == `CMD_MEM_READ_LINE && sec_queued_cmd == `CMD_MEM_READ
            |=> !sec_cmd_match;
    endproperty
    a_exact: assert property (p_exact)
        else $error("exact match violated");

    c_serr: cover property (serr_en_r && master_timeout_evt ##1 status_r[7]);
    c_stop: cover property (sec_en_r && mode_r ##1 sec_clk_stopped);
    c_wr_alias: cover property (pri_retry_cmd == `CMD_MEM_WRITE_INV ##1 pri_cmd_match);

endmodule

/* verif/bridge_core_model.sv */
// stand-in for the bridge core: error events, delivery attempts, clock-run levels, commands
module bridge_core_model (
    // clock
    input  wire logic       core_clk,
    // event, failed-attempt and retire pulses
    output      logic [4:0] evt,
    output      logic [2:0] fail,
    output      logic [2:0] done,
    // clock-run levels
    output      logic       stop_req,
    output      logic       bus_idle,
    output      logic       req_pending,
    // retried and queued commands
    output      logic [3:0] pri_retry,
    output      logic [3:0] pri_queued,
    output      logic [3:0] sec_retry,
    output      logic [3:0] sec_queued
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [10:0] pv;

    // pulse vector split onto the event lines
    assign evt  = pv[4:0];
    assign fail = pv[7:5];
    assign done = pv[10:8];

    // everything quiet at time zero
    initial begin
        pv = '0;
        {stop_req, bus_idle, req_pending} = 3'b000;
        {pri_retry, pri_queued, sec_retry, sec_queued} = 16'h0000;
    end

    // one-cycle pulse on line k, dropped at the next edge
    task automatic pulse(input int k);
        @(posedge core_clk);
        pv[k] <= 1'b1;
        @(posedge core_clk);
        pv <= '0;
    endtask

    // clock-run levels, held until changed
    task automatic set_levels(input logic s, input logic i, input logic p);
        @(posedge core_clk);
        stop_req    <= s;
        bus_idle    <= i;
        req_pending <= p;
    endtask

    // retry and queued command codes, held until changed
    task automatic set_cmds(input logic [15:0] c);
        @(posedge core_clk);
        {pri_retry, pri_queued, sec_retry, sec_queued} <= c;
    endtask
endmodule

/* verif/bridge_error_clockrun_retry_options_bench.sv */
// self-checking bench of the system-error status, clock-run and retry option registers
`include "bridge_err_cfg.svh"

module bridge_error_clockrun_retry_options_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [24:0] LIMIT = 25'h0000004; // short retry limit

    logic        core_clk    = 1'b0;
    logic        rst         = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic [31:0] reg_wdata   = 32'h0;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [31:0] reg_rdata;
    logic [4:0]  evt;
    logic [2:0]  fail;
    logic [2:0]  done;
    logic        stop_req;
    logic        bus_idle;
    logic        req_pending;
    logic [3:0]  pri_retry;
    logic [3:0]  pri_queued;
    logic [3:0]  sec_retry;
    logic [3:0]  sec_queued;
    logic        serr_out;
    logic        sec_clock_run_control_en;
    logic        pri_clock_run_control_en;
    logic        sec_clk_stopped;
    logic        pri_clk_stop_allow;
    logic        pri_match;
    logic        sec_match;
    int          miscompares = 0;
    int          checks_done = 0;
    int          evt_bit [5] = '{16, 17, 19, 20, 23};
    int          nod_bit [3] = '{18, 21, 22};
    logic [31:0] cr_w [7]    = '{32'h0a000000, 32'h0b000000, 32'h1a000000, 32'h1a000000,
                                 32'h1a000000, 32'h08000000, 32'h0e000000};
    logic [2:0]  cr_l [7]    = '{3'b100, 3'b010, 3'b010, 3'b100, 3'b011, 3'b110, 3'b100};
    logic        cr_e [7]    = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    // {expect, rd alias, wr alias, line/multiple alias}, 0, retried, queued
    logic [15:0] mt [10]     = '{16'hc0e6, 16'hc0c6, 16'h00e6, 16'h50f7, 16'ha0f7,
                                 16'h90ec, 16'h90ce, 16'h40ec, 16'h8066, 16'h7076};

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    bridge_core_model bridge_core_model_inst (
        .core_clk    (core_clk),
        .evt         (evt),
        .fail        (fail),
        .done        (done),
        .stop_req    (stop_req),
        .bus_idle    (bus_idle),
        .req_pending (req_pending),
        .pri_retry   (pri_retry),
        .pri_queued  (pri_queued),
        .sec_retry   (sec_retry),
        .sec_queued  (sec_queued)
    );

    bridge_error_clockrun_retry_options #(.RETRY_LIMIT(LIMIT))
        bridge_error_clockrun_retry_options_inst (
        .core_clk                 (core_clk),
        .rst                      (rst),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .addr_parity_evt          (evt[0]),
        .posted_parity_evt        (evt[1]),
        .posted_tabort_evt        (evt[2]),
        .posted_mabort_evt        (evt[3]),
        .master_timeout_evt       (evt[4]),
        .attempt_fail             (fail),
        .attempt_done             (done),
        .primary_system_error_out (serr_out),
        .pri_stop_req             (stop_req),
        .sec_bus_idle             (bus_idle),
        .pri_req_pending          (req_pending),
        .sec_clock_run_control_en            (sec_clock_run_control_en),
        .pri_clock_run_control_en            (pri_clock_run_control_en),
        .sec_clk_stopped          (sec_clk_stopped),
        .pri_clk_stop_allow       (pri_clk_stop_allow),
        .pri_retry_cmd            (pri_retry),
        .pri_queued_cmd           (pri_queued),
        .pri_cmd_match            (pri_match),
        .sec_retry_cmd            (sec_retry),
        .sec_queued_cmd           (sec_queued),
        .sec_cmd_match            (sec_match)
    );

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // pulse line k, expect a one-cycle system error or none
    task automatic fire(input int k, input logic exp);
        bridge_core_model_inst.pulse(k);
        #1;
        check({31'h0, serr_out}, {31'h0, exp});
        @(posedge core_clk);
        #1;
        check({31'h0, serr_out}, 32'h0);
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        logic [15:0] f;
        logic [31:0] o;
        logic [31:0] e;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        // reset values and an unmapped place
        read_check(`OFF_SERR_STATUS, 32'h0);
        read_check(`OFF_CLOCK_RUN, 32'h0);
        read_check(`OFF_RETRY_OPTIONS, {25'h0, `OPTIONS_RESET});
        reg_write(8'h80, 32'hffffffff);
        read_check(8'h80, 32'h0);
        // no system error while the command enable is clear
        fire(0, 1'b0);
        read_check(`OFF_SERR_STATUS, 32'h0);
        reg_write(`OFF_COMMAND, 32'h00000100);
        // direct events: output, status bit, write-one clear
        for (int i = 0; i < 5; i++) begin
            fire(i, 1'b1);
            read_check(`OFF_SERR_STATUS, 32'h1 << evt_bit[i]);
            reg_write(`OFF_SERR_STATUS, 32'h1 << evt_bit[i]);
            read_check(`OFF_SERR_STATUS, 32'h0);
        end
        // clear and event in one cycle: the event wins
        fork
            bridge_core_model_inst.pulse(3);
            reg_write(`OFF_SERR_STATUS, 32'h00100000);
        join
        read_check(`OFF_SERR_STATUS, 32'h00100000);
        reg_write(`OFF_SERR_STATUS, 32'h00100000);
        read_check(`OFF_SERR_STATUS, 32'h0);
        // disabled events stay silent
        for (int i = 1; i < 4; i++) begin
            reg_write(`OFF_EVENT_DISABLE, 32'h1 << (evt_bit[i] - 16));
            fire(i, 1'b0);
            read_check(`OFF_SERR_STATUS, 32'h0);
        end
        reg_write(`OFF_EVENT_DISABLE, 32'h0);
        // retry counters: retire restarts the count, the limit-th failure reports
        for (int j = 0; j < 3; j++) begin
            repeat (LIMIT - 1) fire(5 + j, 1'b0);
            fire(8 + j, 1'b0);
            repeat (LIMIT - 1) fire(5 + j, 1'b0);
            fire(5 + j, 1'b1);
            read_check(`OFF_SERR_STATUS, 32'h1 << nod_bit[j]);
            reg_write(`OFF_SERR_STATUS, 32'h1 << nod_bit[j]);
            reg_write(`OFF_EVENT_DISABLE, 32'h1 << (nod_bit[j] - 16));
            fire(8 + j, 1'b0);
            repeat (LIMIT) fire(5 + j, 1'b0);
            read_check(`OFF_SERR_STATUS, 32'h0);
            reg_write(`OFF_EVENT_DISABLE, 32'h0);
            fire(8 + j, 1'b0);
        end
        // clock-run modes, enables and primary keep-running
        for (int c = 0; c < 7; c++) begin
            reg_write(`OFF_CLOCK_RUN, cr_w[c]);
            bridge_core_model_inst.set_levels(cr_l[c][2], cr_l[c][1], cr_l[c][0]);
            repeat (4) @(posedge core_clk);
            #1;
            o = {28'h0, sec_clock_run_control_en, pri_clock_run_control_en, sec_clk_stopped, pri_clk_stop_allow};
            e = {28'h0, cr_w[c][25], cr_w[c][27], cr_e[c], cr_w[c][27] & ~cr_w[c][26] & cr_e[c]};
            check(o, e);
            e = (cr_w[c] & 32'hfeffffff) | {7'h0, cr_e[c], 24'h0};
            read_check(`OFF_CLOCK_RUN, e);
        end
        // retry command matching on both sides
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 10; m++) begin
                f = mt[m];
                if (s == 0) begin
                    o = {25'h0, 1'b0, f[12], 2'b00, f[13], f[14], 1'b0};
                    e = {f[7:0], 8'h00, 16'h0};
                end else begin
                    o = {25'h0, f[12], 1'b0, f[13], f[14], 3'b000};
                    e = {24'h0, f[7:0]};
                end
                reg_write(`OFF_RETRY_OPTIONS, o | 32'h1);
                read_check(`OFF_RETRY_OPTIONS, o);
                bridge_core_model_inst.set_cmds(e[31:16] | e[15:0]);
                repeat (3) @(posedge core_clk);
                #1;
                check({31'h0, (s == 0) ? pri_match : sec_match}, {31'h0, f[15]});
            end
        end
        tally_and_finish();
    end
endmodule
